// File: dtio_top.sv
`timescale 1ns/10ps
// terminal processing logic with an apb register file
module dtio_top
   import dtio_pkg::*;
(
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [11:0]               paddr,
   input  wire logic [31:0]               pwdata,
   output logic      [31:0]               prdata,
   output logic                           pready,
   output logic                           pslverr,
   input  wire logic                      cycle_tick,
   input  wire logic                      drive_running,
   input  wire dtio_val_t                 displayed_value,
   input  wire dtio_val_t [6:0]           src_val,
   input  wire dtio_lim_s [8:0]           dest_lim,
   input  wire logic [3:0]                din_pin,
   input  wire logic                      run_pin,
   input  wire logic [3:0]                bid_pin_in,
   output logic      [3:0]                bid_pin_out,
   output logic      [3:0]                bid_pin_oe,
   output dtio_val_t [2:0]                aout_mv,
   output dtio_item_t [6:0]               src_sel,
   output dtio_item_t [8:0]               dest_sel,
   output dtio_val_t [8:0]                dest_val,
   output logic      [3:0]                bid_bin
);

   // whole state of the block in one record
   typedef struct packed {
      dtio_cfg_s             cfg;      // software settings
      logic [3:0]            drv_eff;  // output mode actually in force
      dtio_val_t [2:0]       aout;     // terminal voltages in mV
      dtio_val_t [8:0]       dest;     // delivered destination values
      logic [3:0]            bres;     // comparator after inverter
      logic [3:0]            oe;       // output switch closed
      logic [3:0]            pout;     // terminal drive level
      logic [31:0]           prdata;   // read data for access phase
      logic                  pready;   // access phase answer
      logic                  pslverr;  // unmapped address flag
   } dtio_state_s;

   localparam dtio_state_s ST_RST = '{cfg: cfg_defaults(), default: '0};

   dtio_state_s         st_reg;      // registered state
   dtio_state_s         st_next;     // next state
   dtio_dec_s           dec;         // decoded bus address
   dtio_val_t [2:0]     aout_src;    // selected analog sources
   dtio_val_t [2:0]     aout_calc;   // analog results this cycle
   dtio_val_t [8:0]     dest_calc;   // destination results this cycle
   dtio_val_t [3:0]     cmp_mag;     // comparator left operand
   logic      [3:0]     bid_res;     // comparator results this cycle

   // address to register group, channel and word
   function automatic dtio_dec_s reg_decode(input logic [11:0] a);
      dtio_dec_s  d;
      logic [3:0] din_idx;
      d       = '{kind: R_NONE, ch: 3'h0, fld: 3'h0};
      din_idx = a[7:4] - 4'h4;
      if (a[1:0] != 2'h0) begin
         d.kind = R_NONE;                          // unaligned
      end else if (a < AOUT_BASE + 12'h030) begin
         d = '{kind: R_AOUT, ch: {1'b0, a[5:4]}, fld: {1'b0, a[3:2]}};
      end else if (a >= DIN_BASE && a < DIN_BASE + 12'h050 && a[3:2] != 2'h3) begin
         d = '{kind: R_DIN, ch: din_idx[2:0], fld: {1'b0, a[3:2]}};
      end else if (a >= BID_BASE && a < BID_END && a[4:2] < 3'h6) begin
         d = '{kind: R_BID, ch: {1'b0, a[6:5]}, fld: a[4:2]};
      end else if (a == SCOPE_ADDR) begin
         d.kind = R_SCOPE;
      end else if (a == STAT_ADDR) begin
         d.kind = R_STATUS;
      end
      return d;
   endfunction

   // write data to a saturated pure number
   function automatic dtio_val_t wr_val(input logic [31:0] w);
      return clamp_val(signed'(w), VAL_MIN, VAL_MAX);
   endfunction

   // write data to an item number
   function automatic dtio_item_t wr_item(input logic [31:0] w);
      return (w > 32'(ITEM_MAX)) ? ITEM_MAX : w[9:0];
   endfunction

   // analog channel sources, scope mode overrides the third
   always_comb begin
      for (int c = 0; c < N_AOUT; c++) begin
         aout_src[c] = src_val[c];
      end
      if (st_reg.cfg.scope_en) begin
         aout_src[SCOPE_CH] = displayed_value;
      end
   end

   // analog output paths
   for (genvar c = 0; c < N_AOUT; c++) begin : g_aout
      dtio_aout_calc u_calc (
         .src      (aout_src[c]),
         .cfg      (st_reg.cfg.aout[c]),
         .volts_mv (aout_calc[c])
      );
   end

   // input sensing and output comparators
   always_comb begin
      dest_calc = '0;
      cmp_mag   = '0;
      bid_res   = '0;
      // plain inputs and run input pick high or low value
      for (int i = 0; i < N_DIN; i++) begin
         if ((i == RUN_CH) ? run_pin : din_pin[2'(i)]) begin
            dest_calc[i] = clamp_val(32'(st_reg.cfg.din[i].hi), dest_lim[i].min,
                                     dest_lim[i].max);
         end else begin
            dest_calc[i] = clamp_val(32'(st_reg.cfg.din[i].lo), dest_lim[i].min,
                                     dest_lim[i].max);
         end
      end
      for (int j = 0; j < N_BID; j++) begin
         // terminal level always sensed, even while driving
         if (bid_pin_in[j]) begin
            dest_calc[N_DIN+j] = clamp_val(32'(st_reg.cfg.bid[j].hi), dest_lim[N_DIN+j].min,
                                           dest_lim[N_DIN+j].max);
         end else begin
            dest_calc[N_DIN+j] = clamp_val(32'(st_reg.cfg.bid[j].lo), dest_lim[N_DIN+j].min,
                                           dest_lim[N_DIN+j].max);
         end
         // rectified takes magnitude, bipolar the signed value
         if (st_reg.cfg.bid[j].rect) begin
            cmp_mag[j] = abs_val(src_val[N_AOUT+j]);
         end else begin
            cmp_mag[j] = src_val[N_AOUT+j];
         end
         // strict compare, equality stays low, then optional inversion
         bid_res[j] = (cmp_mag[j] > st_reg.cfg.bid[j].thr) ^ st_reg.cfg.bid[j].inv;
      end
   end

   // bus slave, settings and per-cycle update
   always_comb begin
      st_next = st_reg;
      dec     = reg_decode(paddr);
      // answer in the cycle after setup, zero wait states
      st_next.pready = psel & ~penable;
      if (psel && !penable) begin
         st_next.pslverr = (dec.kind == R_NONE);
         st_next.prdata  = 32'h0000_0000;
         case (dec.kind)
            R_AOUT: begin
               case (dec.fld)
                  3'h0:    st_next.prdata = {22'h000000, st_reg.cfg.aout[dec.ch].src_sel};
                  3'h1:    st_next.prdata = {16'h0000, st_reg.cfg.aout[dec.ch].div};
                  3'h2:    st_next.prdata = {16'h0000, st_reg.cfg.aout[dec.ch].offset};
                  default: st_next.prdata = {31'h00000000, st_reg.cfg.aout[dec.ch].rect};
               endcase
            end
            R_DIN: begin
               case (dec.fld)
                  3'h0:    st_next.prdata = {22'h000000, st_reg.cfg.din[dec.ch].dest_sel};
                  3'h1:    st_next.prdata = {16'h0000, st_reg.cfg.din[dec.ch].hi};
                  default: st_next.prdata = {16'h0000, st_reg.cfg.din[dec.ch].lo};
               endcase
            end
            R_BID: begin
               case (dec.fld)
                  3'h0:    st_next.prdata = {22'h000000, st_reg.cfg.bid[dec.ch].src_sel};
                  3'h1:    st_next.prdata = {16'h0000, st_reg.cfg.bid[dec.ch].thr};
                  3'h2:    st_next.prdata = {29'h00000000, st_reg.cfg.bid[dec.ch].inv,
                                             st_reg.cfg.bid[dec.ch].rect,
                                             st_reg.cfg.bid[dec.ch].drv_en};
                  3'h3:    st_next.prdata = {22'h000000, st_reg.cfg.bid[dec.ch].dest_sel};
                  3'h4:    st_next.prdata = {16'h0000, st_reg.cfg.bid[dec.ch].hi};
                  default: st_next.prdata = {16'h0000, st_reg.cfg.bid[dec.ch].lo};
               endcase
            end
            R_SCOPE:  st_next.prdata = {31'h00000000, st_reg.cfg.scope_en};
            R_STATUS: st_next.prdata = {14'h0000, drive_running, run_pin, din_pin,
                                        bid_pin_in, st_reg.bres, st_reg.drv_eff};
            default:  st_next.prdata = 32'h0000_0000;
         endcase
      end
      // writes land at the end of the access phase
      if (psel && penable && st_reg.pready && pwrite) begin
         case (dec.kind)
            R_AOUT: begin
               case (dec.fld)
                  3'h0:    st_next.cfg.aout[dec.ch].src_sel = wr_item(pwdata);
                  3'h1:    st_next.cfg.aout[dec.ch].div     = wr_val(pwdata);
                  3'h2:    st_next.cfg.aout[dec.ch].offset  = wr_val(pwdata);
                  default: st_next.cfg.aout[dec.ch].rect    = pwdata[0];
               endcase
            end
            R_DIN: begin
               case (dec.fld)
                  3'h0:    st_next.cfg.din[dec.ch].dest_sel = wr_item(pwdata);
                  3'h1:    st_next.cfg.din[dec.ch].hi       = wr_val(pwdata);
                  default: st_next.cfg.din[dec.ch].lo       = wr_val(pwdata);
               endcase
            end
            R_BID: begin
               case (dec.fld)
                  3'h0:    st_next.cfg.bid[dec.ch].src_sel  = wr_item(pwdata);
                  3'h1:    st_next.cfg.bid[dec.ch].thr      = wr_val(pwdata);
                  3'h2: begin
                     st_next.cfg.bid[dec.ch].drv_en = pwdata[0];
                     st_next.cfg.bid[dec.ch].rect   = pwdata[1];
                     st_next.cfg.bid[dec.ch].inv    = pwdata[2];
                  end
                  3'h3:    st_next.cfg.bid[dec.ch].dest_sel = wr_item(pwdata);
                  3'h4:    st_next.cfg.bid[dec.ch].hi       = wr_val(pwdata);
                  default: st_next.cfg.bid[dec.ch].lo       = wr_val(pwdata);
               endcase
            end
            R_SCOPE:  st_next.cfg.scope_en = pwdata[0];
            default:  st_next.cfg = st_reg.cfg;      // status and unmapped ignore writes
         endcase
      end
      // output mode follows its setting only while the drive is stopped
      if (!drive_running) begin
         for (int j = 0; j < N_BID; j++) begin
            st_next.drv_eff[j] = st_reg.cfg.bid[j].drv_en;
         end
      end
      // all terminal and destination results move together
      if (cycle_tick) begin
         st_next.aout = aout_calc;
         st_next.dest = dest_calc;
         st_next.bres = bid_res;
         // switch and drive level move with the results, open switch drives low
         st_next.oe   = st_reg.drv_eff;
         st_next.pout = bid_res & st_reg.drv_eff;
      end
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= ST_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   // outputs straight from flip-flops
   assign prdata      = st_reg.prdata;
   assign pready      = st_reg.pready;
   assign pslverr     = st_reg.pslverr;
   assign aout_mv     = st_reg.aout;
   assign dest_val    = st_reg.dest;
   assign bid_bin     = st_reg.bres;
   assign bid_pin_out = st_reg.pout;
   assign bid_pin_oe  = st_reg.oe;

   // item selections leave straight from the settings
   always_comb begin
      for (int c = 0; c < N_AOUT; c++) begin
         src_sel[c] = st_reg.cfg.aout[c].src_sel;
      end
      for (int j = 0; j < N_BID; j++) begin
         src_sel[N_AOUT+j]  = st_reg.cfg.bid[j].src_sel;
         dest_sel[N_DIN+j]  = st_reg.cfg.bid[j].dest_sel;
      end
      for (int i = 0; i < N_DIN; i++) begin
         dest_sel[i] = st_reg.cfg.din[i].dest_sel;
      end
   end

   // checks on the block's own behaviour
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_drive_mode_hold: assert property (
      drive_running |=> $stable(st_reg.drv_eff))
      else $error("output mode changed while running");

   a_switch_update: assert property (
      cycle_tick |=> bid_pin_oe == $past(st_reg.drv_eff))
      else $error("output switch not following mode");

   a_cycle_stable: assert property (
      !cycle_tick |=> $stable(aout_mv) && $stable(dest_val) && $stable(bid_bin))
      else $error("results changed outside processing cycle");

   a_input_high: assert property (
      cycle_tick && din_pin[0] && dest_lim[0].max >= st_reg.cfg.din[0].hi
      && dest_lim[0].min <= st_reg.cfg.din[0].hi
      |=> dest_val[0] == $past(st_reg.cfg.din[0].hi))
      else $error("digital input high value not delivered");

   a_bidir_sense: assert property (
      cycle_tick && !bid_pin_in[0] && dest_lim[5].max >= st_reg.cfg.bid[0].lo
      && dest_lim[5].min <= st_reg.cfg.bid[0].lo
      |=> dest_val[5] == $past(st_reg.cfg.bid[0].lo))
      else $error("bidir input level not sensed");

   a_compare_equal: assert property (
      cycle_tick && cmp_mag[0] == st_reg.cfg.bid[0].thr
      |=> bid_bin[0] == $past(st_reg.cfg.bid[0].inv))
      else $error("comparator high on equal inputs");

   a_rectify_pos: assert property (
      cycle_tick && st_reg.cfg.aout[0].rect |=> aout_mv[0] >= 16'sh0000)
      else $error("rectified analog output negative");

   a_scope_source: assert property (
      cycle_tick && st_reg.cfg.scope_en && st_reg.cfg.aout[2].div == DIV_UNITY
      && st_reg.cfg.aout[2].offset == 16'sh0000 && !st_reg.cfg.aout[2].rect
      && abs_val(displayed_value) <= AOUT_MAX_MV
      |=> aout_mv[2] == $past(displayed_value))
      else $error("scope output not showing displayed value");

   // switch pairing, bidir high sensing and input clamping on the first channels, then apb answer timing
   a_switch_open: assert property (
      cycle_tick && !st_reg.drv_eff[0] |=> !bid_pin_oe[0] && !bid_pin_out[0])
      else $error("output switch closed while disabled");

   a_switch_closed: assert property (
      cycle_tick && st_reg.drv_eff[0] |=> bid_pin_oe[0] && bid_pin_out[0] == bid_bin[0])
      else $error("terminal not driven by output path");

   a_bidir_high: assert property (
      cycle_tick && bid_pin_in[0] && dest_lim[5].max >= st_reg.cfg.bid[0].hi
      && dest_lim[5].min <= st_reg.cfg.bid[0].hi
      |=> dest_val[5] == $past(st_reg.cfg.bid[0].hi))
      else $error("bidir high level not sensed");

   a_input_clamp: assert property (
      cycle_tick && din_pin[0] && st_reg.cfg.din[0].hi > dest_lim[0].max
      |=> dest_val[0] == $past(dest_lim[0].max))
      else $error("digital input value not clamped");

   a_apb_answer: assert property (
      psel && !penable |=> pready ##1 !pready)
      else $error("apb answer timing wrong");

   c_scope_run:    cover property (cycle_tick && st_reg.cfg.scope_en);
   c_drive_switch: cover property (cycle_tick && st_reg.drv_eff != 4'h0);
   c_bad_address:  cover property (pready && pslverr);
   c_equal_cmp:    cover property (cycle_tick && cmp_mag[0] == st_reg.cfg.bid[0].thr);
   c_clamp_hit:    cover property (cycle_tick && st_reg.cfg.din[0].hi > dest_lim[0].max);

endmodule

// File: dtio_pkg.sv
// Contract
// - analog out: fetch, divide, offset, rectify
// - divider signed, limited +/-3.0000, default +1.0000
// - unity divider: 100.00% gives 10.00 V
// - offset after divider, unaffected by divider
// - scope mode: third output shows displayed value
// - default sources items 715, 123, 718
// - digital input delivers high or low value
// - zero is logic low, nonzero is high
// - defaults high 0.01%, low 0.00%
// - output disabled: switch open, processing continues
// - output enabled: switch closed, terminal driven
// - bidir input always senses terminal level
// - output mode change only while drive stopped
// - rectified compares magnitude, bipolar signed value
// - rectified switches both polarities, bipolar once
// - comparator high only when strictly above threshold
// - inverter then enable switch; result offered internally
// - linear values are +/-30000 signed counts
// - out-of-range destination values are clamped
package dtio_pkg;

   typedef logic signed [15:0] dtio_val_t;   // pure number, 1 count = 0.01 %
   typedef logic [9:0]         dtio_item_t;  // internal item number

   localparam int N_AOUT   = 3;              // analog output channels
   localparam int N_DIN    = 5;              // four digital inputs plus run input
   localparam int N_BID    = 4;              // bidirectional terminals
   localparam int SCOPE_CH = 2;              // channel taken over by scope mode
   localparam int RUN_CH   = 4;              // digital input slot of the run terminal

   localparam dtio_val_t  VAL_MAX     = 16'sh7530;   // +30000 counts
   localparam dtio_val_t  VAL_MIN     = -16'sh7530;  // -30000 counts
   localparam dtio_val_t  DIV_UNITY   = 16'sh2710;   // 1.0000, also 100.00 %
   localparam dtio_val_t  AOUT_MAX_MV = 16'sh2C24;   // 11.300 V terminal swing
   localparam dtio_val_t  HI_RST      = 16'sh0001;   // 0.01 %
   localparam dtio_val_t  LO_RST      = 16'sh0000;   // 0.00 %
   localparam dtio_item_t ITEM_MAX    = 10'h2D0;     // highest item number
   localparam dtio_item_t ITEM_NONE   = 10'h190;     // block disconnect
   localparam dtio_item_t RUN_ITEM    = 10'h134;     // internal run item

   localparam dtio_item_t [N_AOUT-1:0] AOUT_SRC_RST = {10'h2CE, 10'h07B, 10'h2CB};
   localparam dtio_item_t [N_BID-1:0]  BID_DEST_RST = {10'h058, 10'h021, 10'h02A, 10'h074};

   // register map, byte addresses on a 12-bit bus
   localparam logic [11:0] AOUT_BASE  = 12'h000;  // stride 0x10
   localparam logic [11:0] DIN_BASE   = 12'h040;  // stride 0x10
   localparam logic [11:0] BID_BASE   = 12'h100;  // stride 0x20
   localparam logic [11:0] BID_END    = 12'h180;
   localparam logic [11:0] SCOPE_ADDR = 12'h1F0;
   localparam logic [11:0] STAT_ADDR  = 12'h1F4;

   typedef enum logic [2:0] {R_NONE, R_AOUT, R_DIN, R_BID, R_SCOPE, R_STATUS} dtio_reg_e;

   typedef struct packed {
      dtio_reg_e  kind;  // register group
      logic [2:0] ch;    // channel inside group
      logic [2:0] fld;   // word inside channel
   } dtio_dec_s;

   typedef struct packed {
      dtio_item_t src_sel;  // source_select
      dtio_val_t  div;      // out_divide_factor
      dtio_val_t  offset;   // signed offset
      logic       rect;     // rectified mode
   } dtio_aout_cfg_s;

   typedef struct packed {
      dtio_item_t dest_sel;  // destination_select
      dtio_val_t  hi;        // input_high_value
      dtio_val_t  lo;        // value for low level
   } dtio_din_cfg_s;

   typedef struct packed {
      dtio_item_t src_sel;   // output path source
      dtio_val_t  thr;       // output_compare_threshold
      logic       drv_en;    // output_drive_enable as written
      logic       rect;      // output_rectify_enable
      logic       inv;       // output_invert_enable
      dtio_item_t dest_sel;  // input path destination
      dtio_val_t  hi;        // input_high_value
      dtio_val_t  lo;        // value for low level
   } dtio_bid_cfg_s;

   typedef struct packed {
      dtio_val_t max;  // destination upper limit
      dtio_val_t min;  // destination lower limit
   } dtio_lim_s;

   typedef struct packed {
      dtio_aout_cfg_s [N_AOUT-1:0] aout;
      dtio_din_cfg_s  [N_DIN-1:0]  din;
      dtio_bid_cfg_s  [N_BID-1:0]  bid;
      logic                        scope_en;  // scope_monitor_enable
   } dtio_cfg_s;

   // saturate a wide signed value into [lo, hi]
   function automatic dtio_val_t clamp_val(input logic signed [31:0] v,
                                           input dtio_val_t lo, input dtio_val_t hi);
      if (v > 32'(hi)) return hi;
      if (v < 32'(lo)) return lo;
      return dtio_val_t'(v[15:0]);
   endfunction

   // magnitude of a pure number, range is symmetric so it cannot overflow
   function automatic dtio_val_t abs_val(input dtio_val_t v);
      return (v < 0) ? dtio_val_t'(16'sh0000 - v) : v;
   endfunction

   // configuration after reset
   function automatic dtio_cfg_s cfg_defaults();
      dtio_cfg_s c;
      c = '0;
      for (int i = 0; i < N_AOUT; i++) begin
         c.aout[i].src_sel = AOUT_SRC_RST[i];
         c.aout[i].div     = DIV_UNITY;
      end
      for (int i = 0; i < N_DIN; i++) begin
         c.din[i].dest_sel = (i == RUN_CH) ? RUN_ITEM : ITEM_NONE;
         c.din[i].hi       = HI_RST;
         c.din[i].lo       = LO_RST;
      end
      for (int i = 0; i < N_BID; i++) begin
         c.bid[i].src_sel  = ITEM_NONE;
         c.bid[i].dest_sel = BID_DEST_RST[i];
         c.bid[i].hi       = HI_RST;
         c.bid[i].lo       = LO_RST;
      end
      return c;
   endfunction

endpackage

// File: dtio_aout_calc.sv
`timescale 1ns/10ps
// analog output path: divider, offset, rectifier, terminal clamp
module dtio_aout_calc
   import dtio_pkg::*;
(
   input  wire dtio_val_t      src,
   input  wire dtio_aout_cfg_s cfg,
   output dtio_val_t           volts_mv
);

   logic signed [31:0] scaled;   // source times unity over divider
   dtio_val_t          lin;      // after divider
   dtio_val_t          biased;   // after offset

   // 1 count equals 1 mV at the terminal, so 10000 counts give 10.00 V
   always_comb begin
      if (cfg.div == 16'sh0000) begin
         scaled = 32'sh0;                                     // no defined gain
      end else begin
         scaled = (32'(src) * 32'(DIV_UNITY)) / 32'(cfg.div);
      end
      lin    = clamp_val(scaled, VAL_MIN, VAL_MAX);
      biased = clamp_val(32'(lin) + 32'(cfg.offset), VAL_MIN, VAL_MAX);
      if (cfg.rect) begin
         biased = abs_val(biased);
      end
      volts_mv = clamp_val(32'(biased), -AOUT_MAX_MV, AOUT_MAX_MV);
   end

endmodule

// File: dtio_field_model.sv
`timescale 1ns/10ps
// outside wiring on the bidirectional terminals
module dtio_field_model
   import dtio_pkg::*;
(
   input  wire logic [3:0] field_lvl,  // level from outside wiring
   input  wire logic [3:0] pin_out,    // level driven by the block
   input  wire logic [3:0] pin_oe,     // switch closed
   output logic      [3:0] pin_in      // wire level seen by the block
);
   // a closed switch wins the wire, otherwise the field level shows
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & field_lvl);
endmodule

// File: dtio_tb.sv
`timescale 1ns/10ps
module testbench
   import dtio_pkg::*;
;
   logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic              cycle_tick, drive_running, run_pin, tk_d;
   logic [11:0]       paddr;
   logic [31:0]       pwdata, prdata, rng;
   logic [3:0]        din_pin, field_lvl, bid_pin_in, bid_pin_out, bid_pin_oe, bid_bin;
   dtio_val_t         displayed_value;
   dtio_val_t [6:0]   src_val;
   dtio_lim_s [8:0]   dest_lim;
   dtio_val_t [2:0]   aout_mv;
   dtio_val_t [8:0]   dest_val;
   dtio_item_t [6:0]  src_sel;
   dtio_item_t [8:0]  dest_sel;
   logic [35:0]       exq[$];    // expected results, oldest first
   int                n_mismatch, compares;

   dtio_top dtio_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cycle_tick(cycle_tick), .drive_running(drive_running),
      .displayed_value(displayed_value), .src_val(src_val), .dest_lim(dest_lim),
      .din_pin(din_pin), .run_pin(run_pin), .bid_pin_in(bid_pin_in),
      .bid_pin_out(bid_pin_out), .bid_pin_oe(bid_pin_oe), .aout_mv(aout_mv),
      .src_sel(src_sel), .dest_sel(dest_sel), .dest_val(dest_val), .bid_bin(bid_bin));
   dtio_field_model dtio_field_model_inst (.field_lvl(field_lvl), .pin_out(bid_pin_out),
      .pin_oe(bid_pin_oe), .pin_in(bid_pin_in));

   // xorshift step
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction

   // channel 0: divider 0.5, offset +1000, rectified, 11300 mV clamp
   function automatic dtio_val_t ea(input dtio_val_t s);
      int v;
      v = int'(s) * 10000 / 5000 + 1000;
      if (v < 0) v = -v;
      if (v > 11300) v = 11300;
      return dtio_val_t'(v);
   endfunction

   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one apb transfer, waits for pready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, er,
                      input logic ee);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      chk(36'({w ? er : prdata, pslverr, 2'b0}), 36'({er, ee, 2'b0}));
      psel <= 1'b0; penable <= 1'b0;
   endtask

   // one processing cycle with random stimulus
   task automatic tick(input int i, input logic [31:0] r);
      dtio_val_t s0, s3;
      logic      cmp;
      s0 = dtio_val_t'($signed(r[17:4]));
      s3 = 16'sd100 + dtio_val_t'(r[18]);
      if (r[19]) s3 = -s3;
      cmp = (r[0] ? (s3 < 0 ? -s3 : s3) : s3) > 16'sd100;
      @(posedge pclk);
      src_val[0] <= s0; src_val[3] <= s3; din_pin[0] <= r[20]; field_lvl <= r[24:21];
      src_val[4] <= r[25] ? 16'sh0001 : 16'sh0000;  // logic source
      displayed_value <= dtio_val_t'($signed(r[31:18]));
      dest_lim[0].max <= r[2] ? 16'sh1388 : 16'sh7530;
      cycle_tick <= 1'b1;
      drive_running <= (i == 0);
      exq.push_back({ea(s0), r[20] ? (r[2] ? 16'sh1388 : 16'sh4E20) : 16'shFFFF,
                     cmp ^ r[1], (cmp ^ r[1]) & (i > 1), i > 1, r[25]});
      @(posedge pclk);
      cycle_tick <= 1'b0;
   endtask

   // watches results after each tick
   always @(posedge pclk) begin
      tk_d <= cycle_tick;
      if (tk_d)
         chk({aout_mv[0], dest_val[0], bid_bin[0], bid_pin_out[0], bid_pin_oe[0],
              bid_bin[1]}, exq.pop_front());
   end

   task automatic end_of_test();
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   // watchdog
   initial begin
      #1000000;
      n_mismatch++;
      end_of_test();
   end

   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
      cycle_tick = 1'b0; drive_running = 1'b1; run_pin = 1'b1; rng = 32'd53;
      din_pin = '0; field_lvl = '0; displayed_value = '0; src_val = '0; dest_lim = '0;
      dest_lim[0] = {16'sh1388, 16'h8AD0};  // max 5000, min -30000
      dest_lim[5] = {VAL_MAX, VAL_MIN};     // bidir 0 destination spans the full range
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk(36'({src_sel[2:0], 5'h0}), 36'({10'h2CE, 10'h07B, 10'h2CB, 5'h0}));
      chk(36'({dest_sel[5:4], 15'h0}), 36'({10'h074, 10'h134, 15'h0}));
      apb(1'b0, 12'h004, 32'h0, 32'h2710, 1'b0);
      apb(1'b0, 12'h054, 32'h0, 32'h1, 1'b0);
      apb(1'b0, 12'h058, 32'h0, 32'h0, 1'b0);
      apb(1'b0, 12'h1FC, 32'h0, 32'h0, 1'b1);
      apb(1'b1, 12'h004, 32'h1388, 32'h0, 1'b0);
      apb(1'b1, 12'h008, 32'h3E8, 32'h0, 1'b0);
      apb(1'b1, 12'h00C, 32'h1, 32'h0, 1'b0);
      apb(1'b1, 12'h044, 32'h4E20, 32'h0, 1'b0);
      apb(1'b1, 12'h048, 32'hFFFFFFFF, 32'h0, 1'b0);
      apb(1'b1, 12'h104, 32'h64, 32'h0, 1'b0);
      apb(1'b1, 12'h1F0, 32'h1, 32'h0, 1'b0);
      for (int i = 0; i < 24; i++) begin
         rng = xs(rng);
         apb(1'b1, 12'h108, {29'h0, rng[1:0], 1'b1}, 32'h0, 1'b0);
         tick(i, rng);
      end
      repeat (4) @(posedge pclk);
      end_of_test();
   end
endmodule
